// File: rtl/bitmap_access_sequencer.sv
// bit-map access sequencer: arbitration, strobes, address and write-data steering
// assumes all pins synchronous to aclk and an AXI4-Lite master with one access at a time
`include "bitmap_regs.svh"
module bitmap_access_sequencer
    import bitmap_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, low
    input wire logic [7:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [7:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read valid
    input wire logic rready, // read ready
    input wire logic [15:0] gfx_ad_bus, // controller address/data
    input wire logic [1:0] gfx_addr_ext, // plane and byte address bits
    input wire logic gfx_bus_request_n, // controller bus request
    input wire logic gfx_low_write_req_n, // controller write strobe
    input wire logic gfx_row_strobe_n, // controller row strobe
    input wire logic gfx_blanking, // controller blank
    input wire logic video_sync, // sync for blank resampling
    input wire bitmap_pkg::byte_t map_read_data, // bit-map output
    output logic [7:0] mem_mux_addr, // muxed row/column address
    output logic mem_row_strobe, // row strobe
    output logic mem_col_strobe, // column strobe
    output logic mem_write_en, // write phase
    output bitmap_pkg::byte_t map_write_data, // bit-map input
    output logic [15:0] latched_map_addr, // steered address
    output logic plane_addr_bit, // plane select bit
    output logic byte_addr_bit, // byte select bit
    output logic plane_sel_enable, // plane enable
    output logic byte_sel_enable, // byte enable
    output logic high_half_active, // upper bus lines busy
    output bitmap_pkg::byte_t gfx_write_byte, // captured write byte
    output logic [3:0] converter_gate_n, // converter gates, low
    output logic erase_n, // erase, low
    output logic stop_n, // stop, low
    output logic load_readback_n, // read-back load, low
    output logic foreground_intensity, // fg factor
    output logic background_intensity, // bg factor
    output bitmap_pkg::op_mode_e logic_op_mode, // logic unit mode
    output bitmap_pkg::byte_t pattern_write_data, // logic unit output
    output logic space_sel, // high I/O, low memory
    output logic blank, // resynced blank
    output logic [3:0] rom_addr // converter ROM address
);
    import bitmap_pkg::*;

    timing_if tif();
    logic [31:0] ctrl_reg, intens_reg, scroll_reg, wdata_reg;
    logic [7:0] awaddr_reg;
    logic [3:0] wstrb_reg;
    logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [17:0] lat_reg;
    logic [1:0] col_cnt_reg;
    logic col_q_reg, plane_en_reg, byte_en_reg, stop_seen_reg;
    logic blank_reg, rom_run_reg, row_q_reg;
    logic [3:0] rom_cnt_reg, gate_n_reg;
    byte_t gfx_byte_reg, wr_reg, rb_data;

    // ==========================================
    // timing generator and read-back buffer
    rmw_timing u_timing (
        .aclk(aclk),
        .aresetn(aresetn),
        .bus_req_n(gfx_bus_request_n),
        .tif(tif)
    );

    wire byte_eff = ctrl_reg[`CTRL_TEXT] & byte_addr_bit;

    readback_buffer u_rb (
        .aclk(aclk),
        .aresetn(aresetn),
        .load_n(tif.load_readback_n),
        .sel(byte_eff),
        .wr_data(map_read_data),
        .rd_data(rb_data)
    );

    // ==========================================
    // AXI4-Lite slave; address and data may arrive in either order
    wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire do_read = arvalid && arready;
    wire w_ctrl = awaddr_reg == `CTRL_OFS;
    wire w_intens = awaddr_reg == `INTENS_OFS;
    wire w_scroll = awaddr_reg == `SCROLL_OFS;
    wire w_known = w_ctrl || w_intens || w_scroll || awaddr_reg == `STATUS_OFS;
    wire r_known = araddr inside {`CTRL_OFS, `INTENS_OFS, `SCROLL_OFS, `STATUS_OFS};
    assign awready = !aw_hold_reg && !bvalid_reg;
    assign wready = !w_hold_reg && !bvalid_reg;
    assign arready = !rvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;

    // byte lanes merge so a narrow store leaves the other fields alone
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) m[i*8 +: 8] = nw[i*8 +: 8];
        end
        return m;
    endfunction

    // status shows live sequencer state
    wire [31:0] status = {12'h000, rom_cnt_reg, rb_data, 5'h00, stop_seen_reg, high_half_active,
        tif.rmw_active};
    wire [31:0] rd_mux = araddr == `CTRL_OFS ? ctrl_reg :
        araddr == `INTENS_OFS ? intens_reg :
        araddr == `SCROLL_OFS ? scroll_reg :
        araddr == `STATUS_OFS ? status : 32'h0000_0000;

    // write channel holds
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else begin
            if (awvalid && awready) {aw_hold_reg, awaddr_reg} <= {1'b1, awaddr};
            else if (do_write) aw_hold_reg <= 1'b0;
            if (wvalid && wready) {w_hold_reg, wdata_reg, wstrb_reg} <= {1'b1, wdata, wstrb};
            else if (do_write) w_hold_reg <= 1'b0;
        end
    end

    // write response and register updates
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
            ctrl_reg <= `CTRL_RESET;
            intens_reg <= '0;
            scroll_reg <= '0;
        end else begin
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= w_known ? `RESP_OKAY : `RESP_SLVERR;
                if (w_ctrl) ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
                if (w_intens) intens_reg <= merge(intens_reg, wdata_reg, wstrb_reg);
                if (w_scroll) scroll_reg <= merge(scroll_reg, wdata_reg, wstrb_reg);
            end else if (bready) bvalid_reg <= 1'b0;
        end
    end

    // read channel answers one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `RESP_OKAY;
            rdata_reg <= '0;
        end else if (do_read) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= r_known ? `RESP_OKAY : `RESP_SLVERR;
            rdata_reg <= rd_mux;
        end else if (rready) rvalid_reg <= 1'b0;
    end

    // ==========================================
    // control outputs from the control and intensity registers; high-half flag from the upper bus lines
    assign erase_n = ctrl_reg[`CTRL_ERASE_N];
    assign space_sel = ctrl_reg[`CTRL_IO];
    assign logic_op_mode = op_mode_e'(ctrl_reg[`CTRL_MODE]);
    assign foreground_intensity = plane_addr_bit ? intens_reg[`INT_FG1] : intens_reg[`INT_FG0];
    assign background_intensity = plane_addr_bit ? intens_reg[`INT_BG1] : intens_reg[`INT_BG0];
    assign high_half_active = |gfx_ad_bus[15:8];

    // ==========================================
    // address latch and steering; scroll cycles always use plane zero
    assign latched_map_addr = ctrl_reg[`CTRL_SCROLL] ? scroll_reg[15:0] : lat_reg[`LAT_ADDR];
    assign plane_addr_bit = !ctrl_reg[`CTRL_SCROLL] && lat_reg[`LAT_PLANE];
    assign byte_addr_bit = lat_reg[`LAT_BYTE];
    assign mem_mux_addr = tif.col_phase ? latched_map_addr[15:8] : latched_map_addr[7:0];
    assign mem_row_strobe = tif.row_strobe;
    assign mem_col_strobe = tif.col_strobe;
    assign mem_write_en = tif.write_en;
    assign stop_n = tif.stop_n;
    assign load_readback_n = tif.load_readback_n;

    // latch the address only between cycles so it is steady under the strobes
    always_ff @(posedge aclk) begin
        if (!aresetn) lat_reg <= '0;
        else if (!gfx_bus_request_n && !tif.row_strobe) lat_reg <= {gfx_addr_ext, gfx_ad_bus};
    end

    // write byte taken from the half picked by the byte bit when text mode is set, else the low half
    always_ff @(posedge aclk) begin
        if (!aresetn) gfx_byte_reg <= '0;
        else if (!gfx_low_write_req_n) gfx_byte_reg <= byte_eff ? gfx_ad_bus[15:8] : gfx_ad_bus[7:0];
    end
    assign gfx_write_byte = gfx_byte_reg;

    // ==========================================
    // plane and byte enables follow the first and second column strobe
    wire col_rise = tif.col_strobe && !col_q_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn || !tif.row_strobe) begin
            col_q_reg <= 1'b0;
            col_cnt_reg <= `COL_FIRST;
            plane_en_reg <= 1'b0;
            byte_en_reg <= 1'b0;
        end else begin
            col_q_reg <= tif.col_strobe;
            if (col_rise) col_cnt_reg <= col_cnt_reg + 2'h1;
            if (col_rise && col_cnt_reg == `COL_FIRST) plane_en_reg <= 1'b1;
            if (col_rise && col_cnt_reg == `COL_SECOND) byte_en_reg <= 1'b1;
        end
    end
    assign plane_sel_enable = plane_en_reg;
    assign byte_sel_enable = byte_en_reg;

    // ==========================================
    // logic unit and write-data source
    wire [7:0] pat = intens_reg[`INT_PAT];
    always_comb begin
        case (logic_op_mode)
            OP_REPLACE: pattern_write_data = (pat & {8{foreground_intensity}}) | (~pat & {8{background_intensity}});
            OP_COMPLEMENT: pattern_write_data = rb_data ^ pat;
            OP_SET: pattern_write_data = rb_data | pat;
            OP_CLEAR: pattern_write_data = rb_data & ~pat;
            default: pattern_write_data = rb_data;
        endcase
    end

    // loaded in the gap so it is ready when the write column strobe rises
    always_ff @(posedge aclk) begin
        if (!aresetn) wr_reg <= '0;
        else if (!tif.load_readback_n) begin
            case (wsrc_e'(ctrl_reg[`CTRL_WSRC]))
                SRC_PATTERN: wr_reg <= pattern_write_data;
                SRC_MAP: wr_reg <= map_read_data;
                default: wr_reg <= gfx_byte_reg;
            endcase
        end
    end
    assign map_write_data = wr_reg;

    // ==========================================
    // blank resampled on sync, stop remembered for status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blank_reg <= 1'b1;
            stop_seen_reg <= 1'b0;
        end else begin
            if (video_sync) blank_reg <= gfx_blanking;
            if (!tif.stop_n) stop_seen_reg <= 1'b1;
            else if (tif.rmw_active) stop_seen_reg <= 1'b0;
        end
    end
    assign blank = blank_reg;

    // ==========================================
    // converter ROM counter and gates; counter parks at its last count
    wire row_fall = row_q_reg && !gfx_row_strobe_n;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            row_q_reg <= 1'b1;
            rom_run_reg <= 1'b0;
            rom_cnt_reg <= `ROM_FIRST;
        end else begin
            row_q_reg <= gfx_row_strobe_n;
            if (row_fall) {rom_run_reg, rom_cnt_reg} <= {1'b1, `ROM_FIRST};
            else if (rom_run_reg) begin
                rom_cnt_reg <= rom_cnt_reg + 4'h1;
                if (rom_cnt_reg == `ROM_LAST - 4'h1) rom_run_reg <= 1'b0;
            end
        end
    end
    assign rom_addr = rom_cnt_reg;

    for (genvar g = 0; g < 4; g++) begin : g_gate
        always_ff @(posedge aclk) begin
            if (!aresetn) gate_n_reg[g] <= g != 0;
            else gate_n_reg[g] <= rom_cnt_reg[1:0] != 2'(g);
        end
    end
    assign converter_gate_n = gate_n_reg;

    // ==========================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    plane_enable_a: assert property ($rose(tif.row_strobe) ##1 col_rise |=> plane_sel_enable && !byte_sel_enable)
        else $error("plane enable not on first column strobe");
    byte_enable_a: assert property (col_rise && col_cnt_reg == `COL_SECOND |-> !byte_sel_enable ##1 byte_sel_enable)
        else $error("byte enable not on second column strobe");
    erase_write_a: assert property (do_write && w_ctrl && wstrb_reg[0] |=> erase_n == $past(wdata_reg[0]))
        else $error("erase output did not follow control write");
    one_gate_a: assert property ($onehot(~converter_gate_n))
        else $error("converter gates not one-hot");
    write_half_a: assert property (!gfx_low_write_req_n && !byte_eff |=> gfx_write_byte == $past(gfx_ad_bus[7:0]))
        else $error("low half not taken");
    high_flag_a: assert property (gfx_ad_bus[15:8] == 8'h00 |-> !high_half_active)
        else $error("high-half flag without upper lines");
    rom_start_a: assert property (row_fall |=> rom_addr == `ROM_FIRST ##1 rom_addr == `ROM_FIRST + 4'h1)
        else $error("converter counter did not start");
    addr_mux_a: assert property ($rose(tif.col_phase) |-> mem_mux_addr == latched_map_addr[15:8]
        && $past(mem_mux_addr) == $past(latched_map_addr[7:0]))
        else $error("row then column address order broken");
endmodule

// File: rtl/bitmap_pkg.sv
// types shared by the bit-map sequencer files
// assumes nothing of its surroundings
package bitmap_pkg;
    typedef logic [7:0] byte_t;
    typedef enum {T_IDLE, T_ROW, T_COL1, T_GAP, T_COL2, T_END} rmw_state_e;
    typedef enum logic [1:0] {SRC_GFX, SRC_PATTERN, SRC_MAP, SRC_SPARE} wsrc_e;
    typedef enum logic [1:0] {OP_REPLACE, OP_COMPLEMENT, OP_SET, OP_CLEAR} op_mode_e;
endpackage

// File: rtl/bitmap_regs.svh
// register offsets, field positions and reset values of the bit-map sequencer
// assumes an 8-bit byte address on the AXI4-Lite slave
`ifndef BITMAP_REGS_SVH
`define BITMAP_REGS_SVH
// ==========================================
// offsets
`define CTRL_OFS 8'h00
`define INTENS_OFS 8'h04
`define SCROLL_OFS 8'h08
`define STATUS_OFS 8'h0C
// ==========================================
// control fields
`define CTRL_RESET 32'h0000_0001
`define CTRL_ERASE_N 0
`define CTRL_SCROLL 1
`define CTRL_TEXT 2
`define CTRL_IO 3
`define CTRL_MODE 5:4
`define CTRL_WSRC 7:6
// ==========================================
// intensity and pattern fields
`define INT_FG0 0
`define INT_FG1 1
`define INT_BG0 2
`define INT_BG1 3
`define INT_PAT 15:8
// ==========================================
// status fields
`define ST_RMW 0
`define ST_HIGH 1
`define ST_STOP 2
`define ST_RB 15:8
`define ST_ROM 19:16
// ==========================================
// latched address layout and counts
`define LAT_ADDR 15:0
`define LAT_PLANE 16
`define LAT_BYTE 17
`define COL_FIRST 2'h0
`define COL_SECOND 2'h1
`define ROM_FIRST 4'h0
`define ROM_LAST 4'hF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: rtl/readback_buffer.sv
// two-byte read-back buffer for bit-map output data
// assumes load_n is a level from the timing generator
module readback_buffer
    import bitmap_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, low
    input wire logic load_n, // capture when low
    input wire logic sel, // byte lane
    input wire bitmap_pkg::byte_t wr_data, // bit-map output
    output bitmap_pkg::byte_t rd_data // registered read
);
    byte_t mem_reg [2];

    // ==========================================
    // storage, one entry per byte lane
    for (genvar i = 0; i < 2; i++) begin : g_lane
        always_ff @(posedge aclk) begin
            if (!aresetn) mem_reg[i] <= '0;
            else if (!load_n && sel == 1'(i)) mem_reg[i] <= wr_data;
        end
    end

    // read out of a flop so the write mux sees a stable byte
    always_ff @(posedge aclk) begin
        if (!aresetn) rd_data <= '0;
        else rd_data <= load_n ? mem_reg[sel] : wr_data;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    load_capture_a: assert property (!load_n |=> rd_data == $past(wr_data))
        else $error("read-back buffer missed a load");
endmodule

// File: rtl/rmw_timing.sv
// timing generator: row and column strobes of one read-modify-write cycle
// assumes the request input is synchronous to aclk
module rmw_timing
    import bitmap_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, low
    input wire logic bus_req_n, // display controller request
    timing_if.gen tif // strobes out
);
    rmw_state_e state_reg, state_next;

    // ==========================================
    // sequence: row, read column, load gap, write column, end
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            T_IDLE: if (!bus_req_n) state_next = T_ROW;
            T_ROW: state_next = T_COL1;
            T_COL1: state_next = T_GAP;
            T_GAP: state_next = T_COL2;
            T_COL2: state_next = T_END;
            T_END: state_next = bus_req_n ? T_IDLE : T_ROW;
            default: state_next = T_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) state_reg <= T_IDLE;
        else state_reg <= state_next;
    end

    // strobes other than stop_n decode from the state flop alone, so they never glitch between cycles
    assign tif.row_strobe = state_reg inside {T_ROW, T_COL1, T_GAP, T_COL2};
    assign tif.col_phase = state_reg inside {T_COL1, T_GAP, T_COL2};
    assign tif.col_strobe = state_reg inside {T_COL1, T_COL2};
    assign tif.load_readback_n = state_reg != T_GAP;
    assign tif.write_en = state_reg == T_COL2;
    assign tif.cycle_end = state_reg == T_END;
    assign tif.stop_n = !(tif.cycle_end && bus_req_n);
    assign tif.rmw_active = state_reg != T_IDLE;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    stop_when_idle_a: assert property (tif.cycle_end && bus_req_n |-> !tif.stop_n ##1 !tif.rmw_active)
        else $error("no stop at cycle end");
    rmw_restart_a: assert property (tif.cycle_end && !bus_req_n |-> tif.stop_n ##1 tif.row_strobe)
        else $error("pending request did not launch a cycle");
    col_pair_a: assert property ($rose(tif.row_strobe) |=> tif.col_strobe ##1 !tif.col_strobe ##1 tif.col_strobe)
        else $error("column strobes out of order");
    reset_idle_a: assert property ($rose(aresetn) |-> !tif.row_strobe && !tif.col_strobe)
        else $error("strobes active after reset");
endmodule

// File: rtl/timing_if.sv
// strobes from the timing generator to the access sequencer
// assumes one clock shared by both ends
interface timing_if;
    logic row_strobe;
    logic col_strobe;
    logic col_phase;
    logic cycle_end;
    logic load_readback_n;
    logic write_en;
    logic stop_n;
    logic rmw_active;
    modport gen (output row_strobe, col_strobe, col_phase, cycle_end, load_readback_n, write_en, stop_n,
        rmw_active);
    modport user (input row_strobe, col_strobe, col_phase, cycle_end, load_readback_n, write_en, stop_n,
        rmw_active);
endinterface

// File: sim/bitmap_access_sequencer_test.sv
// self-checking bench of the access sequencer
// assumes gfx_partner as the far side
module bitmap_access_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, go = 0;
    logic gfx_blanking = 1, video_sync = 0;
    logic [7:0] awaddr = 0, araddr = 0, mem_byte = 0, mem_mux_addr, map_read_data, map_write_data;
    logic [7:0] gfx_write_byte, pattern_write_data;
    logic [31:0] wdata = 0, seed = 32'hD3EC, rnd, rdata;
    logic [15:0] addr = 0, gfx_ad_bus, latched_map_addr;
    logic [1:0] ext = 0, bresp, rresp, gfx_addr_ext, logic_op_mode;
    logic awready, wready, bvalid, arready, rvalid, gfx_bus_request_n, gfx_low_write_req_n, gfx_row_strobe_n;
    logic mem_row_strobe, mem_col_strobe, mem_write_en, plane_addr_bit, byte_addr_bit, plane_sel_enable;
    logic byte_sel_enable, high_half_active, erase_n, stop_n, load_readback_n, foreground_intensity;
    logic background_intensity, space_sel, blank;
    logic [3:0] converter_gate_n, rom_addr;
    logic [6:0] walk [6] = '{7'h49, 7'h69, 7'h45, 7'h7D, 7'h0E, 7'h09};
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int n_errors = 0, checked = 0, cycles = 0;
    bitmap_access_sequencer i_bitmap_access_sequencer (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .gfx_ad_bus, .gfx_addr_ext, .gfx_bus_request_n, .gfx_low_write_req_n, .gfx_row_strobe_n,
        .gfx_blanking, .video_sync, .map_read_data, .mem_mux_addr, .mem_row_strobe, .mem_col_strobe, .mem_write_en,
        .map_write_data, .latched_map_addr, .plane_addr_bit, .byte_addr_bit, .plane_sel_enable, .byte_sel_enable,
        .high_half_active, .gfx_write_byte, .converter_gate_n, .erase_n, .stop_n, .load_readback_n,
        .foreground_intensity, .background_intensity, .logic_op_mode, .pattern_write_data, .space_sel, .blank,
        .rom_addr);
    gfx_partner i_gfx_partner (.aclk, .go, .addr, .ext, .mem_byte, .mem_row_strobe, .gfx_bus_request_n,
        .gfx_low_write_req_n, .gfx_row_strobe_n, .gfx_ad_bus, .gfx_addr_ext, .map_read_data);
    // ==
    initial forever #10 aclk = ~aclk;
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // write: both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        rready <= 0;
    endtask
    // answers are compared with the oldest note; a hang ends the run
    always @(posedge aclk) begin
        if (bvalid === 1'b1 && bready === 1'b1) check(bresp, bq.pop_front());
        if (rvalid === 1'b1 && rready === 1'b1) check({rresp, rdata}, rq.pop_front());
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            final_report;
        end
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        video_sync <= 1;
        gfx_blanking <= 0;
        @(negedge aclk);
        check({stop_n, load_readback_n, erase_n, mem_row_strobe, converter_gate_n}, 8'hEE);
        wr(8'h40, 0, 2'h2); // unmapped write must leave erase off
        rd(8'h00, 1);
        check(blank, 0);
        for (int i = 0; i < 4; i++) begin
            rnd = $random(seed);
            wr(8'h04, rnd, 0);
            wr(8'h00, {24'h0, 2'h2, i[1:0], i[0], i[1], 1'b0, i[0]}, 0);
            check({logic_op_mode, space_sel, erase_n}, {i[1:0], i[0], i[0]});
            addr <= rnd[31:16];
            ext <= rnd[5:4];
            mem_byte <= rnd[15:8];
            go <= 1;
            @(posedge aclk);
            go <= 0;
            for (int c = 0; c < 6; c++) begin
                @(negedge aclk);
                check({mem_row_strobe, mem_col_strobe, mem_write_en, load_readback_n, plane_sel_enable,
                    byte_sel_enable, stop_n}, walk[c]);
                if (c < 2) check(mem_mux_addr, c ? addr[15:8] : addr[7:0]);
                if (c == 3) check(map_write_data, mem_byte);
            end
            check({latched_map_addr, plane_addr_bit, byte_addr_bit, high_half_active},
                {addr, ext[0], ext[1], |addr[15:8]});
            check(gfx_write_byte, (ext[1] & i[1]) ? addr[15:8] : addr[7:0]);
            check({foreground_intensity, background_intensity}, {rnd[ext[0]], rnd[2 + ext[0]]});
            check($countones(converter_gate_n), 3);
        end
        repeat (20) @(posedge aclk);
        check(rom_addr, 4'hF);
        wr(8'h08, 32'h0000_A5C3, 0);
        wr(8'h00, 32'h0000_0003, 0);
        check(latched_map_addr, 16'hA5C3);
        final_report;
    end
endmodule

// File: sim/gfx_partner.sv
// far side model: display controller and bit-map array
// assumes the bench pulses go for one clock per access
module gfx_partner (
    input wire logic aclk, // clock
    input wire logic go, // start one access
    input wire logic [15:0] addr, // access address
    input wire logic [1:0] ext, // plane and byte bits
    input wire logic [7:0] mem_byte, // stored byte
    input wire logic mem_row_strobe, // array row strobe
    output logic gfx_bus_request_n, // request, low
    output logic gfx_low_write_req_n, // write, low
    output logic gfx_row_strobe_n, // row strobe, low
    output logic [15:0] gfx_ad_bus, // address/data
    output logic [1:0] gfx_addr_ext, // address bits
    output logic [7:0] map_read_data // array output
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy_reg = 1'b0;
    logic [7:0] last_reg = 8'h00;
    // ==
    // request held until the row strobe shows the grant
    always_ff @(posedge aclk) begin
        busy_reg <= go | (busy_reg & ~mem_row_strobe);
        last_reg <= map_read_data;
    end
    assign gfx_bus_request_n = ~(go | busy_reg);
    assign gfx_low_write_req_n = gfx_bus_request_n;
    assign gfx_row_strobe_n = gfx_bus_request_n;
    assign gfx_ad_bus = addr;
    assign gfx_addr_ext = ext;
    // unselected array toggles, so a stale byte never passes
    assign map_read_data = mem_row_strobe ? mem_byte : ~last_reg;
endmodule
